// ### hw/fss_consts.vh
// constants for the fieldbus slave state machine block
// Overview of operation
// R1: after reset enter initial state; refuse mailbox and process data there
// R2: master sets channel sync units 0 and 1 as mailbox channels in initial
// R3: initial to configuring accepted only if mailbox channels are valid
// R4: configuring accepts mailbox traffic, no process-data exchange
// R5: master sets process-data sync units from 2, mapping units, object mapping
// R6: configuring to safe-outputs needs valid process-data and clock settings
// R7: inputs copied to dual-port memory before safe-outputs is acknowledged
// R8: safe-outputs passes mailbox and process data, refreshes inputs, outputs safe
// R9: with watchdog disabled outputs may follow received data in safe-outputs
// R10: master sends valid output data before requesting running state
// R11: running copies received output data to physical outputs, all traffic open
// R12: firmware-update reachable only from initial state; others rejected
// R13: firmware-update allows only file-transfer mailbox, nothing else
// R14: objects addressed by 16-bit index and 8-bit subindex
// R15: identity and configuration descriptions live from index 0x1000
// R16: channel parameters from index 0x8000, optionally 0x4000
// R17: input objects from 0x6000, output objects from 0x7000
// R18: access follows object attribute; writes to read-only objects rejected
// R19: online writes are saved to non-volatile memory fail-safe
// R20: code word 0x12345678 at 0xF008 suppresses saving until changed or reset
// R21: each channel block sits 16 indices after the previous one
// R22: watchdog expiry forces outputs low, state kept; restarts on exchange
// R23: failed or illegal request keeps state, reports it and flags error
`ifndef FSS_CONSTS_VH
`define FSS_CONSTS_VH
`define FSS_ST_INIT      4'h1
`define FSS_ST_CONFIG    4'h2
`define FSS_ST_BOOT      4'h3
`define FSS_ST_SAFE      4'h4
`define FSS_ST_RUN       4'h8
`define FSS_IDX_IDENT    16'h1000
`define FSS_IDX_ALTCHAN  16'h4000
`define FSS_IDX_INPDO    16'h6000
`define FSS_IDX_OUTPDO   16'h7000
`define FSS_IDX_CHAN     16'h8000
`define FSS_IDX_NOSAVE   16'hF008
`define FSS_NOSAVE_CODE  32'h12345678
`define FSS_RANGE_MASK   16'hF000
`define FSS_WD_MS        100
`define FSS_CLK_KHZ      40000
`define FSS_WD_CYCLES    (`FSS_WD_MS * `FSS_CLK_KHZ)
`endif

// ### hw/fss_state_machine.v
// slave state sequencer with traffic gating, output watchdog and object decode
`timescale 1ns/1ps
`default_nettype none
`include "fss_consts.vh"
module fss_state_machine #(
    parameter [31:0] WD_CYCLES = `FSS_WD_CYCLES,
    parameter        NUM_CH    = 8
) (
    // clock and reset
    input  wire         core_clk,
    input  wire         srst,
    // state request from master
    input  wire         reqValid,
    input  wire [3:0]   reqState,
    input  wire         mbxCfgOk,
    input  wire         pdCfgOk,
    input  wire         dcCfgOk,
    // state report
    output reg  [3:0]   curState,
    output reg          reqAck,
    output reg          reqError,
    // traffic gating
    output wire         mbxEnable,
    output wire         fileOnlyMbx,
    output wire         pdEnable,
    // process data
    input  wire         pdExchange,
    input  wire [NUM_CH-1:0] rxOutData,
    input  wire [NUM_CH-1:0] inPins,
    input  wire         wdEnable,
    output reg  [NUM_CH-1:0] outPins,
    output reg  [NUM_CH-1:0] dpmInputs,
    output reg          wdExpired,
    // object dictionary access
    input  wire         objValid,
    input  wire         objWrite,
    input  wire [15:0]  objIndex,
    input  wire [7:0]   objSub,
    input  wire         objReadOnly,
    input  wire [31:0]  objWdata,
    output reg          objAck,
    output reg          objReject,
    output reg  [2:0]   objRange,
    output reg  [11:0]  objChannel,
    output reg          nvSaveReq,
    output reg          skipPersistentSave
);
    localparam [2:0] RG_OTHER = 3'h0;
    localparam [2:0] RG_IDENT = 3'h1;
    localparam [2:0] RG_ALTCH = 3'h2;
    localparam [2:0] RG_INPDO = 3'h3;
    localparam [2:0] RG_OUTPD = 3'h4;
    localparam [2:0] RG_CHAN  = 3'h5;

    // state codes double as the request codes the master sends
    localparam [3:0] ST_INIT   = `FSS_ST_INIT;
    localparam [3:0] ST_CONFIG = `FSS_ST_CONFIG;
    localparam [3:0] ST_BOOT   = `FSS_ST_BOOT;
    localparam [3:0] ST_SAFE   = `FSS_ST_SAFE;
    localparam [3:0] ST_RUN    = `FSS_ST_RUN;

    reg  [NUM_CH-1:0] inSync1;
    reg  [NUM_CH-1:0] inSync2;
    reg  [31:0]       wdCount;
    reg  [3:0]        next_state;
    reg               next_ok;
    wire              inSafe = (curState == ST_SAFE);
    wire              inRun  = (curState == ST_RUN);
    wire              inBoot = (curState == ST_BOOT);

    assign mbxEnable   = (curState == ST_CONFIG) | inSafe | inRun | inBoot; // R1 R4 R8 R11
    assign fileOnlyMbx = inBoot; // R13
    assign pdEnable    = inSafe | inRun; // R1 R4 R8 R11 R13

    // legal moves; backward moves are allowed except from boot, which may only return to initial
    always @* begin
        next_state = curState;
        next_ok    = 1'b0;
        case (curState)
            ST_INIT: begin
                case (reqState)
                    ST_INIT:   next_ok = 1'b1;
                    ST_CONFIG: next_ok = mbxCfgOk; // R3
                    ST_BOOT:   next_ok = 1'b1; // R12
                    default:   next_ok = 1'b0;
                endcase
            end
            ST_CONFIG: begin
                case (reqState)
                    ST_INIT:   next_ok = 1'b1;
                    ST_CONFIG: next_ok = 1'b1;
                    ST_SAFE:   next_ok = pdCfgOk & dcCfgOk; // R6
                    default:   next_ok = 1'b0;
                endcase
            end
            ST_SAFE: begin
                // update request from here falls to default and is refused
                case (reqState)
                    ST_INIT:   next_ok = 1'b1;
                    ST_CONFIG: next_ok = 1'b1;
                    ST_SAFE:   next_ok = 1'b1;
                    ST_RUN:    next_ok = 1'b1;
                    default:   next_ok = 1'b0; // R12
                endcase
            end
            ST_RUN: begin
                case (reqState)
                    ST_INIT:   next_ok = 1'b1;
                    ST_CONFIG: next_ok = 1'b1;
                    ST_SAFE:   next_ok = 1'b1;
                    ST_RUN:    next_ok = 1'b1;
                    default:   next_ok = 1'b0; // R12
                endcase
            end
            ST_BOOT: begin
                // boot leaves only through initial
                case (reqState)
                    ST_INIT:   next_ok = 1'b1;
                    ST_BOOT:   next_ok = 1'b1;
                    default:   next_ok = 1'b0;
                endcase
            end
            default: next_ok = 1'b0;
        endcase
        if (next_ok)
            next_state = reqState;
    end

    always @(posedge core_clk) begin
        if (srst) begin
            curState <= ST_INIT; // R1
            reqAck   <= 1'b0;
            reqError <= 1'b0;
        end else begin
            reqAck <= 1'b0;
            if (reqValid) begin
                reqAck <= 1'b1;
                if (next_ok) begin
                    curState <= next_state;
                    reqError <= 1'b0;
                end else begin
                    reqError <= 1'b1; // R23
                end
            end
        end
    end

    // pins cross in through two flops
    always @(posedge core_clk) begin
        if (srst) begin
            inSync1   <= {NUM_CH{1'b0}};
            inSync2   <= {NUM_CH{1'b0}};
            dpmInputs <= {NUM_CH{1'b0}};
        end else begin
            inSync1 <= inPins;
            inSync2 <= inSync1;
            // snapshot on entry to safe-outputs, same edge as the ack
            if (reqValid && next_ok && next_state == ST_SAFE &&
                curState == ST_CONFIG)
                dpmInputs <= inSync2; // R7
            else if (inSafe | inRun)
                dpmInputs <= inSync2; // R8
        end
    end

    // watchdog counts only while armed; a zero-width timeout is not offered
    always @(posedge core_clk) begin
        if (srst) begin
            wdCount   <= 32'h00000000;
            wdExpired <= 1'b0;
        end else if (!wdEnable || !pdEnable || pdExchange) begin
            wdCount   <= 32'h00000000; // R22
            wdExpired <= 1'b0;
        end else if (wdCount >= WD_CYCLES - 32'h00000001) begin
            wdExpired <= 1'b1; // R22
        end else begin
            wdCount <= wdCount + 32'h00000001;
        end
    end

    always @(posedge core_clk) begin
        if (srst)
            outPins <= {NUM_CH{1'b0}};
        else if (wdExpired)
            outPins <= {NUM_CH{1'b0}}; // R22
        else if (inRun)
            outPins <= rxOutData; // R11
        else if (inSafe && !wdEnable)
            outPins <= rxOutData; // R9
        else
            outPins <= {NUM_CH{1'b0}}; // R8
    end

    // object dictionary decode, index plus subindex
    always @(posedge core_clk) begin
        if (srst) begin
            objAck             <= 1'b0;
            objReject          <= 1'b0;
            objRange           <= RG_OTHER;
            objChannel         <= 12'h000;
            nvSaveReq          <= 1'b0;
            skipPersistentSave <= 1'b0; // R20
        end else begin
            objAck    <= objValid;
            nvSaveReq <= 1'b0;
            if (objValid) begin
                case (objIndex & `FSS_RANGE_MASK) // R14
                    `FSS_IDX_IDENT:   objRange <= RG_IDENT; // R15
                    `FSS_IDX_ALTCHAN: objRange <= RG_ALTCH; // R16
                    `FSS_IDX_INPDO:   objRange <= RG_INPDO; // R17
                    `FSS_IDX_OUTPDO:  objRange <= RG_OUTPD; // R17
                    `FSS_IDX_CHAN:    objRange <= RG_CHAN; // R16
                    default:          objRange <= RG_OTHER;
                endcase
                objChannel <= {4'h0, objIndex[11:4]}; // R21
                objReject  <= objWrite & objReadOnly; // R18
                if (objWrite && !objReadOnly) begin
                    if (objIndex == `FSS_IDX_NOSAVE && objSub == 8'h00) begin
                        skipPersistentSave <= (objWdata == `FSS_NOSAVE_CODE); // R20
                    end else begin
                        nvSaveReq <= ~skipPersistentSave; // R19
                    end
                end
            end
        end
    end
endmodule // fss_state_machine
`default_nettype wire

// ### tb/fss_asserts.sv
// concurrent checks on the state sequencer ports
`timescale 1ns/1ps
`default_nettype none
module fss_asserts #(
    parameter NUM_CH = 8
) (
    // clock and reset
    input wire logic              core_clk,
    input wire logic              srst,
    // requests
    input wire logic              reqValid,
    input wire logic [3:0]        reqState,
    input wire logic              mbxCfgOk,
    input wire logic              wdEnable,
    input wire logic              objValid,
    input wire logic [15:0]       objIndex,
    // answers
    input wire logic [3:0]        curState,
    input wire logic              reqAck,
    input wire logic              reqError,
    input wire logic              mbxEnable,
    input wire logic              fileOnlyMbx,
    input wire logic              pdEnable,
    input wire logic [NUM_CH-1:0] outPins,
    input wire logic              wdExpired,
    input wire logic              objAck,
    input wire logic [2:0]        objRange,
    input wire logic [11:0]       objChannel
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    init_gate_a: assert property (curState == 4'h1 |-> !mbxEnable && !pdEnable)
        else $error("traffic open in initial state");
    cfg_gate_a: assert property (curState == 4'h2 |-> mbxEnable && !pdEnable)
        else $error("wrong gating in configuring state");
    boot_gate_a: assert property (curState == 4'h3 |-> fileOnlyMbx && !pdEnable)
        else $error("wrong gating in update state");
    req_ack_a: assert property (reqValid |=> reqAck)
        else $error("request not acknowledged");
    mbx_check_a: assert property (reqValid && reqState == 4'h2 && curState == 4'h1
        && !mbxCfgOk |=> curState == 4'h1 && reqError) else $error("bad mailbox accepted");
    boot_only_a: assert property (reqValid && reqState == 4'h3 && curState inside {4'h2,
        4'h4, 4'h8} |=> curState == $past(curState) && reqError) else $error("update entered");
    safe_hold_a: assert property (curState == 4'h4 && $past(curState) == 4'h4 && wdEnable
        && $past(wdEnable) |-> outPins == '0) else $error("outputs driven in safe state");
    wd_force_a: assert property ($rose(wdExpired) |=> outPins == '0
        && curState == $past(curState)) else $error("watchdog did not clear outputs");
    chan_step_a: assert property (objValid |=> objAck
        && objChannel[7:0] == $past(objIndex[11:4])) else $error("channel decode wrong");
    chan_range_a: assert property (objValid && objIndex[15:12] == 4'h8 |=> objRange == 3'h5)
        else $error("channel range code wrong");
    cover property (reqValid && reqState == 4'h4 ##1 curState == 4'h4);
    cover property ($rose(wdExpired));
    cover property (curState == 4'h3);
endmodule // fss_asserts
`default_nettype wire

// ### tb/fss_master_model.sv
// bus master stand-in issuing state requests and channel settings
`timescale 1ns/1ps
`default_nettype none
module fss_master_model (
    // clock
    input wire logic       core_clk,
    // toward the slave
    output var logic       reqValid,
    output var logic [3:0] reqState,
    output var logic       mbxCfgOk,
    output var logic       pdCfgOk,
    output var logic       dcCfgOk,
    output var logic       pdExchange,
    output var logic [7:0] rxOutData
);
    initial {reqValid, reqState, mbxCfgOk, pdCfgOk, dcCfgOk, pdExchange, rxOutData} = '0;
    task setup(input logic mbx, input logic pd);
        mbxCfgOk = mbx;
        {pdCfgOk, dcCfgOk} = {pd, pd};
        rxOutData = pd ? 8'hA5 : 8'h5A;
    endtask
    task move(input logic [3:0] s);
        @(negedge core_clk);
        {reqValid, reqState} = {1'b1, s};
        @(negedge core_clk);
        reqValid = 1'b0;
        // code not held once the request is gone
        reqState = ~s;
    endtask
    task xchg;
        @(negedge core_clk) pdExchange = 1'b1;
        @(negedge core_clk) pdExchange = 1'b0;
    endtask
endmodule // fss_master_model
`default_nettype wire

// ### tb/tb.sv
// self-checking bench for the state sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic core_clk = 1'b0, srst = 1'b1, wdEnable = 1'b0;
    logic objValid = 1'b0, objWrite = 1'b0, objReadOnly = 1'b0;
    logic [15:0] objIndex = '0;
    logic [7:0] objSub = 8'hFF, inPins = 8'h3C;
    logic [31:0] objWdata = '0;
    wire logic reqValid, mbxCfgOk, pdCfgOk, dcCfgOk, pdExchange, reqAck, reqError;
    wire logic mbxEnable, fileOnlyMbx, pdEnable, wdExpired, objAck, objReject;
    wire logic nvSaveReq, skipPersistentSave;
    wire logic [3:0] reqState, curState;
    wire logic [7:0] rxOutData, outPins, dpmInputs;
    wire logic [2:0] objRange;
    wire logic [11:0] objChannel;
    int n_mismatch = 0, n_checks = 0;
    fss_master_model mst_u (
        .core_clk(core_clk), .reqValid(reqValid), .reqState(reqState), .mbxCfgOk(mbxCfgOk),
        .pdCfgOk(pdCfgOk), .dcCfgOk(dcCfgOk), .pdExchange(pdExchange), .rxOutData(rxOutData)
    );
    fss_state_machine #(.WD_CYCLES(20)) dut_u (
        .core_clk(core_clk), .srst(srst), .reqValid(reqValid), .reqState(reqState),
        .mbxCfgOk(mbxCfgOk), .pdCfgOk(pdCfgOk), .dcCfgOk(dcCfgOk), .curState(curState),
        .reqAck(reqAck), .reqError(reqError), .mbxEnable(mbxEnable), .fileOnlyMbx(fileOnlyMbx),
        .pdEnable(pdEnable), .pdExchange(pdExchange), .rxOutData(rxOutData), .inPins(inPins),
        .wdEnable(wdEnable), .outPins(outPins), .dpmInputs(dpmInputs), .wdExpired(wdExpired),
        .objValid(objValid), .objWrite(objWrite), .objIndex(objIndex), .objSub(objSub),
        .objReadOnly(objReadOnly), .objWdata(objWdata), .objAck(objAck), .objReject(objReject),
        .objRange(objRange), .objChannel(objChannel), .nvSaveReq(nvSaveReq),
        .skipPersistentSave(skipPersistentSave)
    );
    always #12.5 core_clk = ~core_clk;
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
        end
    endtask
    task req(input logic [3:0] s);
        mst_u.move(s);
        chk("ack", 1, reqAck);
    endtask
    task obj(input logic w, input logic ro, input logic [15:0] i, input logic [31:0] d);
        @(negedge core_clk);
        {objValid, objWrite, objReadOnly, objIndex, objWdata} = {1'b1, w, ro, i, d};
        @(negedge core_clk);
        objValid = 1'b0;
        chk("objAck", 1, objAck);
    endtask
    task t_boot;
        chk("gates", 0, {curState == 4'h1, mbxEnable, pdEnable} ^ 3'b100);
        req(4'h3);
        chk("boot", 4'h3, {fileOnlyMbx, pdEnable, curState} ^ 6'h20);
        req(4'h2);
        chk("skip", 5'h13, {reqError, curState});
        req(4'h1);
    endtask
    task t_seq;
        req(4'h2);
        chk("mbxBad", 5'h11, {reqError, curState});
        mst_u.setup(1, 0);
        req(4'h2);
        chk("cfg", 6'h22, {mbxEnable, pdEnable, curState});
        req(4'h3);
        chk("bootRej", 2, curState);
        req(4'h4);
        chk("pdBad", 5'h12, {reqError, curState});
        mst_u.setup(1, 1);
        wdEnable = 1'b1;
        req(4'h4);
        repeat (3) @(negedge core_clk);
        chk("safe", {2'b11, 4'h4, 8'h00, inPins}, {mbxEnable, pdEnable, curState, outPins, dpmInputs});
        inPins = 8'hC3;
        repeat (4) @(negedge core_clk);
        chk("refresh", 8'hC3, dpmInputs);
        wdEnable = 1'b0;
        repeat (2) @(negedge core_clk);
        chk("wdOff", 8'hA5, outPins);
    endtask
    task t_run;
        req(4'h8);
        @(negedge core_clk);
        chk("run", {2'b11, 4'h8, 8'hA5}, {mbxEnable, pdEnable, curState, outPins});
        wdEnable = 1'b1;
        repeat (24) @(negedge core_clk);
        chk("wd", {1'b1, 4'h8, 8'h00}, {wdExpired, curState, outPins});
        mst_u.xchg;
        repeat (2) @(negedge core_clk);
        chk("wdClr", {1'b0, 8'hA5}, {wdExpired, outPins});
        req(4'h1);
    endtask
    task t_obj;
        logic [95:0] ix;
        logic [17:0] rg;
        ix = {16'h1000, 16'h4000, 16'h6000, 16'h7000, 16'h8010, 16'hF008};
        rg = {3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0};
        for (int i = 5; i >= 0; i--) begin
            obj(0, 0, ix[16*i +: 16], 0);
            chk("range", {rg[3*i +: 3], 4'h0, ix[16*i+4 +: 8]}, {objRange, objChannel});
        end
        obj(1, 1, 16'h8020, 7);
        chk("ro", 2'b10, {objReject, nvSaveReq});
        obj(1, 0, 16'h8020, 7);
        chk("save", 2'b01, {objReject, nvSaveReq});
        objSub = 8'h00;
        obj(1, 0, 16'hF008, 32'h12345678);
        obj(1, 0, 16'h8020, 7);
        chk("noSave", 2'b10, {skipPersistentSave, nvSaveReq});
        obj(1, 0, 16'hF008, 0);
        chk("skipClr", 0, skipPersistentSave);
        obj(1, 0, 16'hF008, 32'h12345678);
        req(4'h2);
        srst = 1'b1;
        repeat (2) @(negedge core_clk);
        srst = 1'b0;
        chk("rstClr", 6'h01, {mbxEnable, skipPersistentSave, curState});
    endtask
    task complete_run;
        if (n_mismatch == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge core_clk);
        srst = 1'b0;
        t_boot;
        t_seq;
        t_run;
        t_obj;
        complete_run;
    end
    initial begin
        repeat (3000) @(posedge core_clk);
        n_mismatch++;
        complete_run;
    end
endmodule // tb
bind fss_state_machine fss_asserts #(.NUM_CH(NUM_CH)) chk_u (
    .core_clk(core_clk), .srst(srst), .reqValid(reqValid), .reqState(reqState),
    .mbxCfgOk(mbxCfgOk), .wdEnable(wdEnable), .objValid(objValid), .objIndex(objIndex),
    .curState(curState), .reqAck(reqAck), .reqError(reqError), .mbxEnable(mbxEnable),
    .fileOnlyMbx(fileOnlyMbx), .pdEnable(pdEnable), .outPins(outPins),
    .wdExpired(wdExpired), .objAck(objAck), .objRange(objRange), .objChannel(objChannel)
);
`default_nettype wire
